// file: rtl/embedded_memory_block.sv
// Purpose: Configurable RAM / ROM / search memory block
// Assumes: All clocks other than clk arrive as pins and become enables
// Notes: Clears are synchronous to clk, which is the only real clock
//
// How it works
// RULE1: Aspect ratios 128x16 down to 2048x1
// RULE2: Write pulse made internally from clock
// RULE3: Registered writes, optional output register
// RULE4: Page decoder selects block for deep memory
// RULE5: Exactly one page driver enabled
// RULE6: Write clock and separate read clock
// RULE7: Separate enables and clears per side
// RULE8: Input clock for inputs, output clock
// RULE9: Local, global or chip reset clears registers
// RULE10: Single port shares address and clock
// RULE11: True dual port from two blocks
// RULE12: Parallel search returns location and flag
// RULE13: Search holds 32 entries of 32
// RULE14: Wildcard bits never block a match
// RULE15: Encoded output gives binary entry index
// RULE16: Unencoded hits over two 16-lane cycles
// RULE17: Avoid duplicates when using encoded output
// RULE18: Entry write two cycles, three with mask
// RULE19: Contents from configuration or runtime writes
// RULE20: Each input and output independently registered
// RULE21: Lookup mode is configured read-only table
// RULE22: Same address read returns old data
//
// The register addresses and the plain strobed port were decided locally.
`timescale 1ns/1ps
module embedded_memory_block #(
	parameter embedded_memory_block_pkg::mode_t MODE =
		embedded_memory_block_pkg::MODE_RW_CLOCK,
	parameter logic [2:0] ASPECT = embedded_memory_block_pkg::ASPECT_128X16,
	parameter logic [embedded_memory_block_pkg::PAGE_SEL_W-1:0] PAGE_ID =
		'0,
	parameter bit REG_DIN = 1'b1,
	parameter bit REG_DOUT = 1'b0,
	parameter bit REG_RADDR = 1'b1,
	parameter bit REG_WADDR = 1'b1,
	parameter bit REG_WE = 1'b1,
	parameter bit REG_RE = 1'b1,
	parameter bit ENCODED = 1'b1,
	parameter logic [embedded_memory_block_pkg::TOTAL_BITS-1:0] INIT_RAM =
		'0,
	parameter logic [1023:0] INIT_CAM = '0
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic global_clear,
	input wire logic in_clk_pin,
	input wire logic out_clk_pin,
	input wire logic wr_clk_en,
	input wire logic rd_clk_en,
	input wire logic wr_clear,
	input wire logic rd_clear,
	input wire logic [embedded_memory_block_pkg::MAX_DATA_W-1:0] wr_data,
	input wire logic [embedded_memory_block_pkg::MAX_ADDR_W-1:0] wr_addr,
	input wire logic write_strobe,
	input wire logic read_strobe,
	input wire logic [embedded_memory_block_pkg::MAX_ADDR_W-1:0] rd_addr,
	input wire logic [embedded_memory_block_pkg::PAGE_SEL_W-1:0] page_sel,
	input wire logic [embedded_memory_block_pkg::CAM_WIDTH-1:0] search_key,
	input wire logic search_strobe,
	input wire logic [embedded_memory_block_pkg::CAM_WIDTH-1:0] cam_wr_word,
	input wire logic [embedded_memory_block_pkg::CAM_WIDTH-1:0] cam_wr_mask,
	input wire logic [embedded_memory_block_pkg::CAM_IDX_W-1:0] cam_wr_idx,
	input wire logic cam_wr_start,
	input wire logic cam_wr_use_mask,
	output logic [embedded_memory_block_pkg::MAX_DATA_W-1:0] rd_data,
	output logic line_drive,
	output logic line_drive_oe_n,
	output logic [embedded_memory_block_pkg::CAM_IDX_W-1:0] match_index,
	output logic match_flag,
	output logic [embedded_memory_block_pkg::HIT_LANES-1:0] hit_lanes,
	output logic hit_upper,
	output logic cam_busy
);
	localparam int AW = embedded_memory_block_pkg::MAX_ADDR_W;
	localparam int DW = embedded_memory_block_pkg::MAX_DATA_W;
	localparam int NB = embedded_memory_block_pkg::TOTAL_BITS;
	localparam int CW = embedded_memory_block_pkg::CAM_WIDTH;
	localparam int CD = embedded_memory_block_pkg::CAM_DEPTH;
	localparam int HL = embedded_memory_block_pkg::HIT_LANES;

	// Word width from aspect code
	function automatic int width_of(input logic [2:0] code);
		return DW >> code;
	endfunction

	// Bit address of bit b of word a for the configured aspect
	function automatic logic [AW-1:0] bit_addr(
		input logic [AW-1:0] a,
		input int b
	);
		logic [AW-1:0] r;
		r = AW'((int'(a) << ($clog2(DW) - int'(ASPECT))) + b);
		return r;
	endfunction

	localparam int WW = width_of(ASPECT); // see RULE1

	// Clock pins become one-cycle enables
	logic in_rise;
	logic out_rise;
	clock_edge_sync u_in_sync (
		.clk(clk),
		.rst_n(rst_n),
		.pin(in_clk_pin),
		.rise(in_rise)
	);
	clock_edge_sync u_out_sync (
		.clk(clk),
		.rst_n(rst_n),
		.pin(out_clk_pin),
		.rise(out_rise)
	);

	// Per-mode tick choice for each register group
	logic wr_tick;
	logic rd_in_tick;
	logic rd_out_tick;
	always_comb begin
		case (MODE)
			embedded_memory_block_pkg::MODE_RW_CLOCK: begin
				wr_tick = in_rise & wr_clk_en; // see RULE6
				rd_in_tick = out_rise & rd_clk_en;
				rd_out_tick = out_rise & rd_clk_en;
			end
			embedded_memory_block_pkg::MODE_IO_CLOCK: begin
				wr_tick = in_rise & wr_clk_en; // see RULE8
				rd_in_tick = in_rise & wr_clk_en;
				rd_out_tick = out_rise & rd_clk_en;
			end
			default: begin
				wr_tick = in_rise & wr_clk_en; // see RULE10
				rd_in_tick = in_rise & wr_clk_en;
				rd_out_tick = in_rise & rd_clk_en;
			end
		endcase
	end

	// Clears: local per side, global, chip reset
	logic wr_clr;
	logic rd_clr;
	assign wr_clr = !rst_n || global_clear || wr_clear; // see RULE9
	assign rd_clr = !rst_n || global_clear || rd_clear; // see RULE7

	// Input register stage, each one optional
	logic [DW-1:0] din_q;
	logic [AW-1:0] waddr_q;
	logic [AW-1:0] raddr_q;
	logic we_q;
	logic re_q;
	always_ff @(posedge clk) begin
		if (wr_clr) begin
			din_q <= 16'h0000;
			waddr_q <= 11'h000;
			we_q <= 1'b0;
		end else if (wr_tick) begin
			din_q <= wr_data; // see RULE3
			waddr_q <= wr_addr;
			we_q <= write_strobe;
		end
	end
	always_ff @(posedge clk) begin
		if (rd_clr) begin
			raddr_q <= 11'h000;
			re_q <= 1'b0;
		end else if (rd_in_tick) begin
			raddr_q <= rd_addr;
			re_q <= read_strobe;
		end
	end

	// Bypass muxes for unregistered inputs
	logic [DW-1:0] din_v;
	logic [AW-1:0] waddr_v;
	logic [AW-1:0] raddr_v;
	logic we_v;
	logic re_v;
	assign din_v = REG_DIN ? din_q : wr_data; // see RULE20
	assign waddr_v = REG_WADDR ? waddr_q : wr_addr;
	assign we_v = REG_WE ? we_q : write_strobe;
	assign re_v = REG_RE ? re_q : read_strobe;
	// Single port uses the write address for both operations
	assign raddr_v = (MODE == embedded_memory_block_pkg::MODE_SINGLE_PORT) ?
		waddr_v : (REG_RADDR ? raddr_q : rd_addr);

	// Internal write pulse: one clk cycle per write tick, no glitch path
	logic wpulse;
	assign wpulse = wr_tick && we_v && !wr_clr &&
		MODE != embedded_memory_block_pkg::MODE_LOOKUP &&
		MODE != embedded_memory_block_pkg::MODE_SEARCH; // see RULE2

	// Bit-organised storage, loaded at configuration
	logic [NB-1:0] mem_q = INIT_RAM; // see RULE21
	always_ff @(posedge clk) begin
		if (wpulse) begin
			for (int b = 0; b < WW; b++) begin
				mem_q[bit_addr(waddr_v, b)] <= din_v[b];
			end
		end
	end

	// Read array; old contents seen because write lands at clock edge
	logic [DW-1:0] rd_word;
	always_comb begin
		rd_word = '0;
		for (int b = 0; b < WW; b++) begin
			rd_word[b] = mem_q[bit_addr(raddr_v, b)]; // see RULE22
		end
	end

	// Read capture and optional output register
	logic [DW-1:0] rdat_q;
	logic [DW-1:0] rout_q;
	always_ff @(posedge clk) begin
		if (rd_clr) begin
			rdat_q <= 16'h0000;
		end else if (rd_in_tick && (re_v ||
			MODE == embedded_memory_block_pkg::MODE_LOOKUP)) begin
			rdat_q <= rd_word;
		end
	end
	always_ff @(posedge clk) begin
		if (rd_clr) begin
			rout_q <= 16'h0000;
		end else if (rd_out_tick) begin
			rout_q <= rdat_q; // see RULE3
		end
	end
	assign rd_data = REG_DOUT ? rout_q : rdat_q;

	// Page decoder: only the selected page drives the shared line
	// Updated every clk, so a held read enable never leaves two drivers on
	logic drive_q;
	always_ff @(posedge clk) begin
		if (rd_clr) begin
			drive_q <= 1'b0;
		end else begin
			drive_q <= (page_sel == PAGE_ID); // see RULE4
		end
	end
	// Low-active enable; decode of page_sel gives one driver per page
	assign line_drive_oe_n = !drive_q; // see RULE5
	assign line_drive = rd_data[0];
	// Dual port with two blocks relies on two instances sharing writes
	// driven by the surrounding logic on both copies.  see RULE11

	// Search write sequencer: capture cycle, then data write, then mask write only when requested
	embedded_memory_block_pkg::cam_wr_state_t cw_q;
	logic [CW-1:0] cw_word_q;
	logic [CW-1:0] cw_mask_q;
	logic [embedded_memory_block_pkg::CAM_IDX_W-1:0] cw_idx_q;
	logic cw_mask_req_q;
	logic cam_data_we;
	logic cam_mask_we;
	always_ff @(posedge clk) begin
		if (wr_clr) begin
			cw_q <= embedded_memory_block_pkg::CW_IDLE;
			cw_word_q <= 32'h00000000;
			cw_mask_q <= 32'h00000000;
			cw_idx_q <= 5'h00;
			cw_mask_req_q <= 1'b0;
		end else begin
			case (cw_q)
				embedded_memory_block_pkg::CW_IDLE: begin
					if (cam_wr_start) begin
						cw_q <= embedded_memory_block_pkg::CW_DATA;
						cw_word_q <= cam_wr_word;
						cw_mask_q <= cam_wr_mask;
						cw_idx_q <= cam_wr_idx;
						cw_mask_req_q <= cam_wr_use_mask;
					end
				end
				embedded_memory_block_pkg::CW_DATA: begin
					cw_q <= cw_mask_req_q ?
						embedded_memory_block_pkg::CW_MASK :
						embedded_memory_block_pkg::CW_IDLE; // see RULE18
				end
				embedded_memory_block_pkg::CW_MASK: begin
					cw_q <= embedded_memory_block_pkg::CW_IDLE;
				end
				default: begin
					cw_q <= embedded_memory_block_pkg::CW_IDLE;
				end
			endcase
		end
	end
	assign cam_data_we = (cw_q == embedded_memory_block_pkg::CW_DATA);
	assign cam_mask_we = (cw_q == embedded_memory_block_pkg::CW_MASK);
	assign cam_busy = (cw_q != embedded_memory_block_pkg::CW_IDLE);

	// Search array, 32 entries of 32 bits
	logic [CD-1:0] hits;
	search_array #(
		.DEPTH(CD),
		.WIDTH(CW),
		.INIT_DATA(INIT_CAM)
	) u_search (
		.clk(clk),
		.clear(!rst_n || global_clear),
		.data_we(cam_data_we),
		.mask_we(cam_mask_we),
		.wr_idx(cw_idx_q),
		.wr_word(cam_data_we ? cw_word_q : cw_mask_q),
		.key(search_key),
		.hits(hits)
	); // see RULE13

	// Priority encode lowest hit; duplicates leave this ambiguous
	function automatic logic [4:0] encode_hit(input logic [CD-1:0] h);
		logic [4:0] r;
		r = 5'h00;
		for (int i = CD - 1; i >= 0; i--) begin
			if (h[i]) begin
				r = i[4:0];
			end
		end
		return r;
	endfunction

	// Search result registers and two-beat unencoded output
	logic [CD-1:0] hits_q;
	logic half_q;
	always_ff @(posedge clk) begin
		if (rd_clr) begin
			match_index <= 5'h00;
			match_flag <= 1'b0;
			hits_q <= 32'h00000000;
			half_q <= 1'b0;
			hit_lanes <= 16'h0000;
			hit_upper <= 1'b0;
		end else if (search_strobe && !cam_busy) begin
			match_flag <= |hits; // see RULE12
			match_index <= ENCODED ? encode_hit(hits) : 5'h00; // see RULE15
			hits_q <= hits; // see RULE17
			hit_lanes <= ENCODED ? 16'h0000 : hits[HL-1:0]; // see RULE16
			hit_upper <= 1'b0;
			half_q <= !ENCODED;
		end else if (half_q) begin
			hit_lanes <= hits_q[CD-1:HL];
			hit_upper <= 1'b1;
			half_q <= 1'b0;
		end else begin
			hit_upper <= 1'b0;
		end
	end
endmodule // embedded_memory_block

// file: rtl/embedded_memory_block_pkg.sv
// Purpose: Shared constants for the configurable memory and search block
// Assumes: One system clock; other clocks are sampled as enables
// Notes: Offsets and counts are used by the core and its helpers
package embedded_memory_block_pkg;
	localparam int TOTAL_BITS = 2048;
	localparam int MAX_ADDR_W = 11;
	localparam int MAX_DATA_W = 16;
	localparam int CAM_DEPTH = 32;
	localparam int CAM_WIDTH = 32;
	localparam int CAM_IDX_W = 5;
	localparam int HIT_LANES = 16;
	localparam int PAGE_SEL_W = 2;
	localparam int SYNC_STAGES = 3;
	// Aspect ratio codes: width = 16 >> code
	localparam logic [2:0] ASPECT_128X16 = 3'h0;
	localparam logic [2:0] ASPECT_256X8 = 3'h1;
	localparam logic [2:0] ASPECT_512X4 = 3'h2;
	localparam logic [2:0] ASPECT_1024X2 = 3'h3;
	localparam logic [2:0] ASPECT_2048X1 = 3'h4;
	// Operating modes
	typedef enum logic [2:0] {
		MODE_RW_CLOCK,
		MODE_IO_CLOCK,
		MODE_SINGLE_PORT,
		MODE_LOOKUP,
		MODE_SEARCH
	} mode_t;
	// Search write sequencer states
	typedef enum logic [1:0] {
		CW_IDLE,
		CW_DATA,
		CW_MASK
	} cam_wr_state_t;
endpackage

// file: rtl/clock_edge_sync.sv
// Purpose: Turn a foreign clock pin into a one-cycle rising-edge enable
// Assumes: The foreign clock is well below half the system rate
// Notes: Three flops; an edge counts when stage two is high and stage three is low
`timescale 1ns/1ps
module clock_edge_sync (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic pin,
	output logic rise
);
	logic [2:0] sync_q;

	// Stage one is only read by stage two, avoiding metastable fanout
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sync_q <= 3'h0;
		end else begin
			sync_q <= {sync_q[1:0], pin};
		end
	end

	assign rise = sync_q[1] & ~sync_q[2];
endmodule // clock_edge_sync

// file: rtl/search_array.sv
// Purpose: 32 x 32 search array with per-bit wildcard and hit vector
// Assumes: Writes come one entry at a time from the core sequencer
// Notes: Comparison is purely combinational across all entries
`timescale 1ns/1ps
module search_array #(
	parameter int DEPTH = embedded_memory_block_pkg::CAM_DEPTH,
	parameter int WIDTH = embedded_memory_block_pkg::CAM_WIDTH,
	parameter logic [DEPTH*WIDTH-1:0] INIT_DATA = '0
) (
	input wire logic clk,
	input wire logic clear,
	input wire logic data_we,
	input wire logic mask_we,
	input wire logic [embedded_memory_block_pkg::CAM_IDX_W-1:0] wr_idx,
	input wire logic [WIDTH-1:0] wr_word,
	input wire logic [WIDTH-1:0] key,
	output logic [DEPTH-1:0] hits
);
	logic [WIDTH-1:0] word_q [DEPTH];
	logic [WIDTH-1:0] care_q [DEPTH];

	// Content load: clear restores configuration contents
	always_ff @(posedge clk) begin
		for (int i = 0; i < DEPTH; i++) begin
			if (clear) begin
				word_q[i] <= INIT_DATA[i*WIDTH +: WIDTH];
				care_q[i] <= '1;
			end else if (data_we && wr_idx == i[4:0]) begin
				word_q[i] <= wr_word; // see RULE19
				care_q[i] <= '1; // Old wildcards must not outlive a rewrite
			end else if (mask_we && wr_idx == i[4:0]) begin
				care_q[i] <= ~wr_word; // 1 in wr_word marks a wildcard
			end
		end
	end

	// Parallel compare, wildcard bits ignored
	always_comb begin
		for (int i = 0; i < DEPTH; i++) begin
			hits[i] = ((word_q[i] ^ key) & care_q[i]) == '0; // see RULE14
		end
	end
endmodule // search_array

// file: dv/clock_pin_model.sv
// Purpose: User logic making one foreign clock pulse per request
// Assumes: Requests last one clk cycle
// Notes: The pin rests low between pulses, like a gated user clock
`timescale 1ns/1ps
module clock_pin_model #(
	parameter int HALF = 4
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic req,
	output logic pin,
	output logic busy
);
	logic [4:0] cnt_q;
	// Count down one whole pulse; a request while busy is dropped
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_q <= 5'h00;
		end else if (req && cnt_q == 5'h00) begin
			cnt_q <= 5'(2 * HALF);
		end else if (cnt_q != 5'h00) begin
			cnt_q <= cnt_q - 5'h01;
		end
	end
	// High in the first half only, so no pulse is ever cut short
	assign pin = cnt_q > 5'(HALF);
	assign busy = cnt_q != 5'h00;
endmodule // clock_pin_model

// file: dv/emb_block_asserts.sv
// Purpose: Port checks of the memory and search block
// Assumes: Clears and reset are synchronous to clk
// Notes: Search checks are off outside search mode
`timescale 1ns/1ps
module emb_block_asserts #(
	parameter embedded_memory_block_pkg::mode_t MODE =
		embedded_memory_block_pkg::MODE_RW_CLOCK,
	parameter logic [2:0] ASPECT = 3'h0,
	parameter logic [1:0] PAGE_ID = 2'h0,
	parameter bit ENCODED = 1'b1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic global_clear,
	input wire logic rd_clear,
	input wire logic [1:0] page_sel,
	input wire logic search_strobe,
	input wire logic cam_wr_start,
	input wire logic cam_wr_use_mask,
	input wire logic [15:0] rd_data,
	input wire logic line_drive_oe_n,
	input wire logic [4:0] match_index,
	input wire logic match_flag,
	input wire logic hit_upper,
	input wire logic cam_busy
);
	localparam bit CAM = MODE == embedded_memory_block_pkg::MODE_SEARCH;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	busy_plain_a: assert property (
		CAM && cam_wr_start && !cam_busy && !cam_wr_use_mask |=>
		cam_busy ##1 !cam_busy) else $error("plain write length");
	busy_mask_a: assert property (
		CAM && cam_wr_start && !cam_busy && cam_wr_use_mask |=>
		cam_busy [*2] ##1 !cam_busy) else $error("masked write length");
	result_hold_a: assert property (
		CAM && !search_strobe && !global_clear && !rd_clear |=>
		$stable(match_flag) && $stable(match_index))
		else $error("search result moved");
	upper_beat_a: assert property (
		CAM && !ENCODED && search_strobe && !cam_busy ##1 !search_strobe &&
		!rd_clear && !global_clear
		|-> !hit_upper ##1 hit_upper) else $error("lane beats out of order");
	global_clr_a: assert property (
		global_clear |=> rd_data == 16'h0000 && !match_flag)
		else $error("global clear missed");
	read_clr_a: assert property (
		!CAM && rd_clear |=> rd_data == 16'h0000)
		else $error("read clear missed");
	page_on_a: assert property (
		(!CAM && page_sel == PAGE_ID && !rd_clear && !global_clear) [*2]
		|-> !line_drive_oe_n)
		else $error("selected page not driving");
	page_off_a: assert property (
		(!CAM && page_sel != PAGE_ID) [*2] |-> line_drive_oe_n)
		else $error("unselected page driving");
	word_width_a: assert property (
		!CAM |-> (32'(rd_data) >> (5'h10 >> ASPECT)) == 32'h0)
		else $error("read data wider than word");
endmodule // emb_block_asserts

bind embedded_memory_block emb_block_asserts #(.MODE(MODE),
	.ASPECT(ASPECT), .PAGE_ID(PAGE_ID), .ENCODED(ENCODED)) chk (
	.clk(clk), .rst_n(rst_n), .global_clear(global_clear),
	.rd_clear(rd_clear), .page_sel(page_sel), .search_strobe(search_strobe),
	.cam_wr_start(cam_wr_start), .cam_wr_use_mask(cam_wr_use_mask),
	.rd_data(rd_data), .line_drive_oe_n(line_drive_oe_n),
	.match_index(match_index), .match_flag(match_flag),
	.hit_upper(hit_upper), .cam_busy(cam_busy));

// file: dv/tb.sv
// Purpose: Directed bench for the memory and search block
// Assumes: Foreign clock pins come from the pulse models
// Notes: Instance 0 is RAM, 1 encoded search, 2 unencoded search, 3 table
`timescale 1ns/1ps
`define check_eq(nm, ex, got) begin checks++; \
	if ((got) !== (ex)) begin fail_count++; \
	$display("BAD %s expected %h seen %h", nm, ex, got); end end
module tb;
	logic clk = 1'b0, rst_n = 1'b0, global_clear = 1'b0, wr_clear = 1'b0;
	logic rd_clear = 1'b0, wr_clk_en = 1'b1, rd_clk_en = 1'b1;
	logic write_strobe = 1'b0, read_strobe = 1'b0, search_strobe = 1'b0;
	logic cam_wr_start = 1'b0, cam_wr_use_mask = 1'b0;
	logic wr_req = 1'b0, rd_req = 1'b0;
	logic in_clk_pin, out_clk_pin, wr_busy, rd_busy;
	logic [15:0] wr_data = 16'h0000;
	logic [10:0] wr_addr = 11'h000, rd_addr = 11'h000;
	logic [1:0] page_sel = 2'h0;
	logic [31:0] search_key = 32'h0, cam_wr_word = 32'h0, cam_wr_mask = 32'h0;
	logic [4:0] cam_wr_idx = 5'h00;
	logic [15:0] rd_data [4];
	logic [15:0] lanes [4];
	logic [4:0] m_idx [4];
	logic line_drive [4], oe_n [4], m_flag [4], upper [4], busy [4];
	int checks = 0, fail_count = 0, cycles = 0;
	always #12.5 clk = ~clk;
	clock_pin_model wr_side (.clk, .rst_n, .req(wr_req), .pin(in_clk_pin),
		.busy(wr_busy));
	clock_pin_model rd_side (.clk, .rst_n, .req(rd_req), .pin(out_clk_pin),
		.busy(rd_busy));
	// One RAM, two search blocks and one lookup table share every input
	for (genvar g = 0; g < 4; g++) begin : u
		embedded_memory_block #(
			.MODE(g == 0 ? embedded_memory_block_pkg::MODE_RW_CLOCK :
				g == 3 ? embedded_memory_block_pkg::MODE_LOOKUP :
				embedded_memory_block_pkg::MODE_SEARCH),
			.ENCODED(g != 2),
			.INIT_RAM(g == 3 ? 2048'h3C96 : 2048'h0)
		) dut (
			.clk, .rst_n, .global_clear, .in_clk_pin, .out_clk_pin,
			.wr_clk_en, .rd_clk_en, .wr_clear, .rd_clear, .wr_data, .wr_addr,
			.write_strobe, .read_strobe, .rd_addr, .page_sel, .search_key,
			.search_strobe, .cam_wr_word, .cam_wr_mask, .cam_wr_idx,
			.cam_wr_start, .cam_wr_use_mask, .rd_data(rd_data[g]),
			.line_drive(line_drive[g]), .line_drive_oe_n(oe_n[g]),
			.match_index(m_idx[g]), .match_flag(m_flag[g]),
			.hit_lanes(lanes[g]), .hit_upper(upper[g]), .cam_busy(busy[g]));
	end
	// One foreign clock pulse, then time for the pin synchroniser
	task automatic pulse(input bit rd);
		int n;
		n = 0;
		@(posedge clk);
		rd_req <= rd;
		wr_req <= !rd;
		@(posedge clk);
		rd_req <= 1'b0;
		wr_req <= 1'b0;
		// Busy shows one edge after the request is taken, so wait first
		do begin
			@(posedge clk);
			n++;
		end while ((wr_busy | rd_busy) === 1'b1 && n < 40);
		repeat (6) @(posedge clk);
	endtask
	task automatic ram_write(input logic [10:0] a, input logic [15:0] d);
		wr_addr <= a;
		wr_data <= d;
		write_strobe <= 1'b1;
		repeat (2) pulse(1'b0);
		write_strobe <= 1'b0;
	endtask
	// Address is taken on one read tick, data lands on the next
	task automatic ram_read(input logic [10:0] a, input logic [15:0] e);
		rd_addr <= a;
		read_strobe <= 1'b1;
		repeat (2) pulse(1'b1);
		read_strobe <= 1'b0;
		`check_eq("rd_data", e, rd_data[0])
	endtask
	task automatic clr(input logic [2:0] c);
		@(posedge clk);
		{global_clear, rd_clear, wr_clear} <= c;
		@(posedge clk);
		{global_clear, rd_clear, wr_clear} <= 3'h0;
		repeat (2) @(posedge clk);
	endtask
	task automatic cam_write(input logic [4:0] i, input logic [31:0] w,
		input logic [31:0] m, input logic um, input int n);
		int k;
		k = 0;
		@(posedge clk);
		cam_wr_idx <= i;
		cam_wr_word <= w;
		cam_wr_mask <= m;
		cam_wr_use_mask <= um;
		cam_wr_start <= 1'b1;
		@(posedge clk);
		cam_wr_start <= 1'b0;
		#1;
		while (busy[1] === 1'b1 && k < 8) begin
			@(posedge clk);
			#1;
			k++;
		end
		`check_eq("write_cycles", n, k + 1)
	endtask
	// Encoded result and low lanes first, high lanes one cycle later
	task automatic cam_find(input logic [31:0] key, input logic [4:0] ix,
		input logic f, input logic [31:0] hv);
		@(posedge clk);
		search_key <= key;
		search_strobe <= 1'b1;
		@(posedge clk);
		search_strobe <= 1'b0;
		#1;
		`check_eq("match_flag", f, m_flag[1])
		if (f) `check_eq("match_index", ix, m_idx[1])
		`check_eq("hits_low", hv[15:0], lanes[2])
		@(posedge clk);
		#1;
		`check_eq("hits_high", hv[31:16], lanes[2])
		`check_eq("hit_upper", 1'b1, upper[2])
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// A hang counts as a mismatch; the run needs about three hundred cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			close_out;
		end
	end
	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		ram_write(11'h000, 16'hA5C3);
		ram_write(11'h07F, 16'h5A3C);
		`check_eq("rom", 16'h3C96, rd_data[3])
		ram_read(11'h000, 16'hA5C3);
		ram_read(11'h07F, 16'h5A3C);
		`check_eq("oe_n", 1'b0, oe_n[0])
		`check_eq("line", 1'b0, line_drive[0])
		page_sel <= 2'h1;
		repeat (3) @(posedge clk);
		`check_eq("oe_n", 1'b1, oe_n[0])
		page_sel <= 2'h0;
		wr_clk_en <= 1'b0;
		ram_write(11'h000, 16'h1111);
		wr_clk_en <= 1'b1;
		ram_read(11'h000, 16'hA5C3);
		`check_eq("line", 1'b1, line_drive[0])
		rd_clk_en <= 1'b0;
		ram_read(11'h07F, 16'hA5C3);
		rd_clk_en <= 1'b1;
		clr(3'h1);
		`check_eq("rd_data", 16'hA5C3, rd_data[0])
		clr(3'h2);
		`check_eq("rd_data", 16'h0000, rd_data[0])
		cam_write(5'h0C, 32'hFA12_0000, 32'h0, 1'b0, 2);
		cam_write(5'h03, 32'h1234_5600, 32'hFF, 1'b1, 3);
		cam_write(5'h1F, 32'hC0DE_0001, 32'h0, 1'b0, 2);
		cam_find(32'hFA12_0000, 5'h0C, 1'b1, 32'h1000);
		cam_find(32'h1234_56AB, 5'h03, 1'b1, 32'h0008);
		cam_find(32'hC0DE_0001, 5'h1F, 1'b1, 32'h8000_0000);
		cam_find(32'h1234_57AB, 5'h00, 1'b0, 32'h0);
		ram_read(11'h07F, 16'h5A3C);
		clr(3'h4);
		`check_eq("rd_data", 16'h0000, rd_data[0])
		cam_find(32'hFA12_0000, 5'h00, 1'b0, 32'h0);
		close_out;
	end
endmodule // tb
